// ==== hdl/psc_counter_bank.sv ====
// Purpose: Per-port transmit statistics counters and all-port drop counters.
// Assumes: Event inputs are one-cycle pulses from logic on sys_clk.
// Notes:   Only transmit offsets 0x19-0x1F are backed; lower offsets read zero.
`default_nettype none
module psc_counter_bank (
	input wire logic sys_clk,
	input wire logic rst,
	psc_link_if.device bus,
	input wire logic [psc_pkg::NUM_PORTS-1:0][psc_pkg::TX_KINDS-1:0] tx_event,
	input wire logic [psc_pkg::NUM_PORTS-1:0] half_duplex,
	input wire logic [psc_pkg::NUM_PORTS-1:0] tx_drop,
	input wire logic [psc_pkg::NUM_PORTS-1:0] rx_drop
);
	import psc_pkg::*;

	// ----------------------------------------------------------------
	// Access model
	// ----------------------------------------------------------------
	// The host never addresses a counter directly. It writes a select code,
	// then the low address byte; that second write is the fetch strobe. The
	// selected counter is copied into one 32-bit snapshot, and the four data
	// registers then hand the snapshot out a byte at a time.
	//
	// Counter address, nine bits:
	//   bit 8 = 0: per-port block, bits 7:5 port, bits 4:0 offset
	//   bit 8 = 1: drop counters, 0x00-0x04 transmit, 0x05-0x09 receive
	// Bit 8 travels in bit 0 of the select code, so the two select codes
	// double as the table choice.
	//
	// Only the transmit offsets 0x19-0x1F hold real counters here. The
	// receive and lower transmit entries live elsewhere; a fetch of one of
	// them returns a valid zero so the host sequence still completes.
	//
	// Limitation: there is one snapshot for all tables, so a second fetch
	// overwrites bytes the host has not yet read. The host must finish its
	// byte reads before it writes the address register again.
	//
	// Trade-off: collision pulses on a full-duplex port are dropped at the
	// input rather than counted and masked later, which keeps the counter
	// free of stale counts when the duplex mode changes.

	// ----------------------------------------------------------------
	// State and fetch decode
	// ----------------------------------------------------------------
	psc_dev_state_type s;
	psc_dev_state_type next_s;
	logic fetch;
	logic [8:0] fetch_addr;
	logic fetch_port;
	logic fetch_in_block;
	logic fetch_drop;
	logic [2:0] fetch_port_idx;
	logic [4:0] fetch_ofs;
	logic [4:0] fetch_kind_wide;
	logic [2:0] fetch_kind;
	logic [3:0] fetch_drop_idx;
	logic [COUNT_W:0] bumped;

	// Increment with carry out so the caller can raise overflow
	function automatic logic [COUNT_W:0] bump(input logic [COUNT_W-1:0] value);
		bump = {1'b0, value} + {{COUNT_W{1'b0}}, 1'b1};
	endfunction : bump

	// Event enable; collisions only count while the port is half duplex
	function automatic logic counts(input logic ev, input int kind, input logic half);
		counts = ev && ((kind != EV_ALL_COLLISION) || half);
	endfunction : counts

	// Drop counters wrap at 16 bits; the host judges wrap from successive reads
	function automatic logic [DROP_W-1:0] drop_next(input logic [DROP_W-1:0] value);
		drop_next = value + {{(DROP_W-1){1'b0}}, 1'b1};
	endfunction : drop_next

	// Decode the address-byte write that starts a fetch
	always_comb begin
		fetch = bus.wr && (bus.addr == REG_ADDR_LO);
		fetch_addr = {s.select[0], bus.wdata};
		fetch_port_idx = fetch_addr[7:PORT_FIELD_LSB];
		fetch_ofs = fetch_addr[PORT_FIELD_LSB-1:0];
		fetch_kind_wide = fetch_ofs - OFS_TX_GROUP;
		fetch_kind = fetch_kind_wide[2:0];
		fetch_drop_idx = fetch_addr[3:0];
		fetch_port = fetch && (s.select == SEL_PORT_READ) && !fetch_addr[ADDR_HIGH_BIT]
			&& (fetch_port_idx < 3'(NUM_PORTS));
		fetch_in_block = fetch_port && (fetch_ofs >= OFS_TX_GROUP);
		fetch_drop = fetch && (s.select == SEL_DROP_READ) && fetch_addr[ADDR_HIGH_BIT]
			&& (fetch_addr[7:0] <= DROP_LAST);
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Snapshot is taken from the current counts, so an event landing in
	// the fetch cycle is kept in the cleared counter rather than lost.
	always_comb begin
		next_s = s;
		next_s.rdata = 8'h00;
		bumped = '0;

		// Control register writes
		if (bus.wr && (bus.addr == REG_SELECT)) begin
			next_s.select = bus.wdata;
		end
		if (bus.wr && (bus.addr == REG_ADDR_LO)) begin
			next_s.addr_lo = bus.wdata;
		end

		// Snapshot the selected counter into the data bytes
		if (fetch_in_block) begin
			next_s.snap = {s.ovf[fetch_port_idx][fetch_kind], 1'b1,
				s.count[fetch_port_idx][fetch_kind]};
		end else if (fetch_port) begin
			// Receive and lower transmit entries are not backed here
			next_s.snap = 32'h4000_0000;
		end else if (fetch_drop) begin
			next_s.snap = {16'h0000, s.drop[fetch_drop_idx]};
		end else if (fetch) begin
			// Refused address: valid flag low tells the host the word is unusable
			next_s.snap = 32'h0000_0000;
		end

		// Per-port transmit counters: clear on fetch, set wins over clear
		for (int p = 0; p < NUM_PORTS; p++) begin
			for (int k = 0; k < TX_KINDS; k++) begin
				if (fetch_in_block && (fetch_port_idx == 3'(p)) && (fetch_kind == 3'(k))) begin
					next_s.count[p][k] = '0;
					next_s.ovf[p][k] = 1'b0;
				end
				// Kinds 0-6 map to offsets 0x19-0x1F in order
				if (counts(tx_event[p][k], k, half_duplex[p])) begin
					bumped = bump(next_s.count[p][k]);
					next_s.count[p][k] = bumped[COUNT_W-1:0];
					if (bumped[COUNT_W]) begin
						next_s.ovf[p][k] = 1'b1;
					end
				end
			end
		end

		// Drop counters wrap silently and are never cleared by reads
		// A read leaves them running, so the host sees a free-running count
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (tx_drop[p]) begin
				next_s.drop[p] = drop_next(s.drop[p]);
			end
			if (rx_drop[p]) begin
				next_s.drop[p + NUM_PORTS] = drop_next(s.drop[p + NUM_PORTS]);
			end
		end

		// Register read, data returned in the following cycle
		// Any read outside the known registers returns zero, so a stray read is harmless
		if (bus.rd) begin
			case (bus.addr)
				REG_SELECT: next_s.rdata = s.select;
				REG_ADDR_LO: next_s.rdata = s.addr_lo;
				REG_DATA_B3: next_s.rdata = s.snap[31:24];
				REG_DATA_B2: next_s.rdata = s.snap[23:16];
				REG_DATA_B1: next_s.rdata = s.snap[15:8];
				REG_DATA_B0: next_s.rdata = s.snap[7:0];
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Everything clears at reset, including the snapshot valid flag
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Read data leaves straight from the register
	assign bus.rdata = s.rdata;

	// Address space per port: 32 block entries plus one transmit and one
	// receive drop counter gives the full per-port set.
	localparam int DROP_PER_PORT = COUNTERS_PER_PORT - BLOCK_ENTRIES;
	localparam logic [8:0] LAST_BLOCK_BASE = 9'(NUM_PORTS - 1) * PORT_BASE_STRIDE;
endmodule : psc_counter_bank
`default_nettype wire

// ==== hdl/psc_pkg.sv ====
// Purpose: Shared constants and types for the port statistics counter bank.
// Assumes: Five ports, byte-wide indirect register access.
// Notes:   Register numbers are kept as byte addresses of the indirect port.
`default_nettype none
package psc_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_PORTS = 5;
	localparam int TX_KINDS = 7;
	localparam int DROP_COUNTERS = 10;
	localparam int COUNT_W = 30;
	localparam int DROP_W = 16;
	localparam int COUNTERS_PER_PORT = 34;
	localparam int BLOCK_ENTRIES = 32;

	// ----------------------------------------------------------------
	// Indirect registers (decimal 110, 111, 117 to 120)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_SELECT = 8'h6E;
	localparam logic [7:0] REG_ADDR_LO = 8'h6F;
	localparam logic [7:0] REG_DATA_B3 = 8'h75;
	localparam logic [7:0] REG_DATA_B2 = 8'h76;
	localparam logic [7:0] REG_DATA_B1 = 8'h77;
	localparam logic [7:0] REG_DATA_B0 = 8'h78;
	localparam logic [7:0] SEL_PORT_READ = 8'h1C;
	localparam logic [7:0] SEL_DROP_READ = 8'h1D;

	// ----------------------------------------------------------------
	// Counter address map
	// ----------------------------------------------------------------
	localparam int PORT_FIELD_LSB = 5;
	localparam logic [8:0] PORT_BASE_STRIDE = 9'h020;
	localparam logic [4:0] OFS_TX_GROUP = 5'h19;
	localparam logic [4:0] OFS_TX_ALL_COLLISION = 5'h1C;
	localparam int EV_ALL_COLLISION = 3;
	localparam logic [7:0] DROP_TX_FIRST = 8'h00;
	localparam logic [7:0] DROP_RX_FIRST = 8'h05;
	localparam logic [7:0] DROP_LAST = 8'h09;

	// ----------------------------------------------------------------
	// Word fields
	// ----------------------------------------------------------------
	localparam int OVF_BIT = 31;
	localparam int VALID_BIT = 30;
	localparam int VALID_BYTE_BIT = 6;
	localparam int ADDR_HIGH_BIT = 8;

	// ----------------------------------------------------------------
	// Host controller software registers
	// ----------------------------------------------------------------
	localparam logic [3:0] HREG_CMD = 4'h0;
	localparam logic [3:0] HREG_STATUS = 4'h1;
	localparam logic [3:0] HREG_RESULT = 4'h2;
	localparam logic [3:0] HREG_DROP_WRAP = 4'h3;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_OVF = 2;
	localparam int ST_RETRY = 3;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_PORTS-1:0][TX_KINDS-1:0][COUNT_W-1:0] count;
		logic [NUM_PORTS-1:0][TX_KINDS-1:0] ovf;
		logic [DROP_COUNTERS-1:0][DROP_W-1:0] drop;
		logic [7:0] select;
		logic [7:0] addr_lo;
		logic [31:0] snap;
		logic [7:0] rdata;
	} psc_dev_state_type;

	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_SEL = 5'h02,
		H_ADDR = 5'h04,
		H_RD = 5'h08,
		H_WAIT = 5'h10
	} psc_host_fsm_type;

	typedef struct packed {
		psc_host_fsm_type fsm;
		logic [7:0] bus_addr;
		logic [7:0] bus_wdata;
		logic bus_wr;
		logic bus_rd;
		logic [8:0] cnt_addr;
		logic [1:0] byte_idx;
		logic [31:0] result;
		logic done;
		logic retried;
		logic [DROP_COUNTERS-1:0][DROP_W-1:0] last_drop;
		logic [DROP_COUNTERS-1:0] wrap;
		logic [31:0] sw_rdata;
	} psc_host_state_type;
endpackage : psc_pkg
`default_nettype wire

// ==== hdl/psc_link_if.sv ====
// Purpose: Byte-wide indirect register link between host and counter bank.
// Assumes: Both ends on sys_clk; read data one cycle after the read strobe.
// Notes:   Strobes are single-cycle and never both high.
`default_nettype none
interface psc_link_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	modport device (input addr, input wdata, input wr, input rd, output rdata);
	modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : psc_link_if
`default_nettype wire

// ==== hdl/psc_host_ctrl.sv ====
// Purpose: Host end that runs the indirect counter read sequence.
// Assumes: Software port on sys_clk; read data one cycle after sw_rd.
// Notes:   A command written while busy is ignored.
`default_nettype none
module psc_host_ctrl (
	input wire logic sys_clk,
	input wire logic rst,
	psc_link_if.host bus,
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata
);
	import psc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	psc_host_state_type s;
	psc_host_state_type next_s;
	logic is_drop;
	logic [31:0] full;
	logic [3:0] di;

	// One comb process drives every next value
	always_comb begin
		next_s = s;
		next_s.bus_wr = 1'b0;
		next_s.bus_rd = 1'b0;
		next_s.sw_rdata = 32'h0000_0000;
		is_drop = s.cnt_addr[ADDR_HIGH_BIT];
		full = {s.result[23:0], bus.rdata};
		di = s.cnt_addr[3:0];

		// Software clears first so a hardware set in the same cycle wins
		if (sw_wr && (sw_addr == HREG_STATUS) && sw_wdata[ST_DONE]) begin
			next_s.done = 1'b0;
		end
		if (sw_wr && (sw_addr == HREG_DROP_WRAP)) begin
			next_s.wrap = s.wrap & ~sw_wdata[DROP_COUNTERS-1:0];
		end

		case (s.fsm)
			H_IDLE: begin
				if (sw_wr && (sw_addr == HREG_CMD)) begin
					next_s.cnt_addr = sw_wdata[8:0];
					next_s.bus_wr = 1'b1;
					next_s.bus_addr = REG_SELECT;
					// Address bit 8 picks the table and rides in select bit 0
					next_s.bus_wdata = sw_wdata[ADDR_HIGH_BIT] ? SEL_DROP_READ
						: SEL_PORT_READ;
					next_s.retried = 1'b0;
					next_s.fsm = H_SEL;
				end
			end
			H_SEL: begin
				next_s.bus_wr = 1'b1;
				next_s.bus_addr = REG_ADDR_LO;
				next_s.bus_wdata = s.cnt_addr[7:0];
				next_s.fsm = H_ADDR;
			end
			H_ADDR: begin
				// Drop counters only carry the two low bytes
				next_s.byte_idx = is_drop ? 2'd2 : 2'd0;
				next_s.bus_rd = 1'b1;
				next_s.bus_addr = is_drop ? REG_DATA_B1 : REG_DATA_B3;
				next_s.result = 32'h0000_0000;
				next_s.fsm = H_RD;
			end
			H_RD: begin
				next_s.fsm = H_WAIT;
			end
			H_WAIT: begin
				next_s.result = full;
				// One reread only, so a refused address cannot lock the host up
				if ((s.byte_idx == 2'd0) && !bus.rdata[VALID_BYTE_BIT] && !s.retried) begin
					next_s.bus_rd = 1'b1;
					next_s.bus_addr = REG_DATA_B3;
					next_s.result = 32'h0000_0000;
					next_s.retried = 1'b1;
					next_s.fsm = H_RD;
				end else if (s.byte_idx == 2'd3) begin
					next_s.done = 1'b1;
					next_s.fsm = H_IDLE;
					// No flags come back, so wrap is judged against the last value
					if (is_drop && (di < 4'(DROP_COUNTERS))) begin
						if (full[DROP_W-1:0] < s.last_drop[di]) begin
							next_s.wrap[di] = 1'b1;
						end
						next_s.last_drop[di] = full[DROP_W-1:0];
					end
				end else begin
					next_s.byte_idx = s.byte_idx + 2'd1;
					next_s.bus_rd = 1'b1;
					next_s.bus_addr = REG_DATA_B3 + {6'h00, s.byte_idx + 2'd1};
					next_s.fsm = H_RD;
				end
			end
			default: begin
				next_s.fsm = H_IDLE;
			end
		endcase

		// Software reads
		if (sw_rd) begin
			case (sw_addr)
				HREG_CMD: next_s.sw_rdata = {23'h00_0000, s.cnt_addr};
				HREG_STATUS: next_s.sw_rdata = {28'h000_0000, s.retried, s.result[OVF_BIT],
					s.done, (s.fsm != H_IDLE)};
				HREG_RESULT: next_s.sw_rdata = s.result;
				HREG_DROP_WRAP: next_s.sw_rdata = {22'h00_0000, s.wrap};
				default: next_s.sw_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Register the whole state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.fsm <= H_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// Link and software outputs straight from flops
	assign bus.addr = s.bus_addr;
	assign bus.wdata = s.bus_wdata;
	assign bus.wr = s.bus_wr;
	assign bus.rd = s.bus_rd;
	assign sw_rdata = s.sw_rdata;
endmodule : psc_host_ctrl
`default_nettype wire

// ==== test/psc_link_asserts.sv ====
// Purpose: Protocol checks on the link between host end and counter bank.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Watches link signals only; both ends are design code.
`default_nettype none
module psc_link_asserts (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata
);
	import psc_pkg::*;
	// ----------------------------------------------------------------
	// Link checks
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// A strobe collision would make the bank see a half access
	a_strobe_excl: assert property (!(wr && rd))
		else $error("write and read strobes high together");
	a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not zero outside read answer");
	a_sel_then_addr: assert property (wr && addr == REG_SELECT |=> wr && addr == REG_ADDR_LO)
		else $error("select write not followed by address write");
	a_sel_code: assert property (wr && addr == REG_SELECT |->
		wdata == SEL_PORT_READ || wdata == SEL_DROP_READ)
		else $error("unknown select code written");
	a_fetch_then_read: assert property (wr && addr == REG_ADDR_LO |=>
		rd && (addr == REG_DATA_B3 || addr == REG_DATA_B1))
		else $error("no data read after fetch");
	a_drop_start: assert property (wr && addr == REG_SELECT && wdata == SEL_DROP_READ
		|-> ##2 rd && addr == REG_DATA_B1)
		else $error("drop read does not start at byte one");
	a_msb_next: assert property (rd && addr == REG_DATA_B3 |->
		##2 rd && (addr == REG_DATA_B2 || addr == REG_DATA_B3))
		else $error("byte after top byte out of order");
	a_byte_order: assert property (rd && addr == REG_DATA_B2 |-> ##2 rd && addr == REG_DATA_B1)
		else $error("third byte not read after second");
	a_last_byte: assert property (rd && addr == REG_DATA_B1 |-> ##2 rd && addr == REG_DATA_B0)
		else $error("low byte not read after third");
	// Only a fetch of an existing port block must come back flagged valid
	a_valid_flag: assert property (wr && addr == REG_SELECT && wdata == SEL_PORT_READ
		##1 wr && addr == REG_ADDR_LO && wdata[7:5] < 3'(NUM_PORTS)
		##1 rd && addr == REG_DATA_B3 |=> rdata[VALID_BYTE_BIT])
		else $error("fetched word not flagged valid");
endmodule : psc_link_asserts
`default_nettype wire

// ==== test/psc_counter_bank_tb.sv ====
// Purpose: Self-checking bench for host end and counter bank together.
// Assumes: 100 MHz sys_clk, asynchronous active-high reset.
// Notes:   Overflow needs 2^30 events and is not reached; the drop wrap lap
//          takes 65534 cycles.
`default_nettype none
module psc_counter_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import psc_pkg::*;
	// ----------------------------------------------------------------
	// Harness
	// ----------------------------------------------------------------
	logic sys_clk;
	logic rst;
	logic [NUM_PORTS-1:0][TX_KINDS-1:0] tx_event;
	logic [NUM_PORTS-1:0] half_duplex;
	logic [NUM_PORTS-1:0] tx_drop;
	logic [NUM_PORTS-1:0] rx_drop;
	logic [3:0] sw_addr;
	logic [31:0] sw_wdata;
	logic sw_wr;
	logic sw_rd;
	logic [31:0] sw_rdata;
	logic [31:0] r;
	int err_count;
	int n_checks;
	int i;
	// Rows: port, kind, pulses, half duplex
	int rows [8][4] = '{'{0, 0, 2, 0}, '{1, 1, 3, 0}, '{2, 2, 1, 0}, '{3, 3, 4, 1},
		'{3, 3, 4, 0}, '{4, 4, 2, 0}, '{0, 5, 1, 0}, '{4, 6, 5, 0}};

	psc_link_if psc_link_if_i ();
	psc_counter_bank psc_counter_bank_i (.sys_clk(sys_clk), .rst(rst), .bus(psc_link_if_i),
		.tx_event(tx_event), .half_duplex(half_duplex), .tx_drop(tx_drop), .rx_drop(rx_drop));
	psc_host_ctrl psc_host_ctrl_i (.sys_clk(sys_clk), .rst(rst), .bus(psc_link_if_i),
		.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata));
	psc_link_asserts psc_link_asserts_i (.sys_clk(sys_clk), .rst(rst),
		.addr(psc_link_if_i.addr), .wdata(psc_link_if_i.wdata), .wr(psc_link_if_i.wr),
		.rd(psc_link_if_i.rd), .rdata(psc_link_if_i.rdata));

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask : check

	task sw_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge sys_clk);
		sw_wr <= 1'b0;
	endtask : sw_write

	// Read data stands only in the cycle after the strobe
	task sw_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge sys_clk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask : sw_read

	// Start a fetch, poll done under a bound, take result, clear done
	task run_cmd(input logic [8:0] a, output logic [31:0] res);
		logic [31:0] st;
		int k;
		sw_write(HREG_CMD, {23'h0, a});
		st = '0;
		for (k = 0; k < 40 && st[ST_DONE] !== 1'b1; k++) begin
			sw_read(HREG_STATUS, st);
		end
		check("done seen", 32'h0000_0001, {31'h0, st[ST_DONE]});
		sw_read(HREG_RESULT, res);
		sw_write(HREG_STATUS, 32'h0000_0002);
	endtask : run_cmd

	task pulse_tx(input int p, input int k, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			tx_event[p][k] <= 1'b1;
			@(posedge sys_clk);
			tx_event[p][k] <= 1'b0;
		end
	endtask : pulse_tx

	task conclude;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	// Watchdog: the drop wrap lap takes 65534 cycles, the rest a few hundred
	initial begin
		repeat (80000) @(posedge sys_clk);
		err_count++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		tx_event = '0;
		half_duplex = '0;
		tx_drop = '0;
		rx_drop = '0;
		sw_addr = 4'h0;
		sw_wdata = 32'h0000_0000;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		err_count = 0;
		n_checks = 0;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		sw_read(HREG_STATUS, r);
		check("status after reset", 32'h0000_0000, r);
		sw_read(HREG_RESULT, r);
		check("result after reset", 32'h0000_0000, r);
		// Every transmit kind, block base and duplex case; second fetch reads cleared
		for (i = 0; i < 8; i++) begin
			half_duplex <= rows[i][3] ? 5'h1F : 5'h00;
			pulse_tx(rows[i][0], rows[i][1], rows[i][2]);
			run_cmd(9'(rows[i][0] * 32 + 25 + rows[i][1]), r);
			check("tx counter", 32'h4000_0000 + ((rows[i][1] == 3 && rows[i][3] == 0) ? 0 :
				rows[i][2]), r);
			run_cmd(9'(rows[i][0] * 32 + 25 + rows[i][1]), r);
			check("tx counter after read", 32'h4000_0000, r);
		end
		// Unbacked offset in port one block reads valid zero
		run_cmd(9'h02E, r);
		check("receive offset", 32'h4000_0000, r);
		// Second command while busy must be dropped
		pulse_tx(1, 1, 2);
		sw_write(HREG_CMD, 32'h0000_003A);
		sw_read(HREG_STATUS, r);
		check("busy flag", 32'h0000_0001, r);
		run_cmd(9'h019, r);
		check("busy command", 32'h4000_0002, r);
		sw_read(HREG_CMD, r);
		check("command readback", 32'h0000_003A, {23'h0, r[8:0]});
		// Drop counters: three transmit, two receive, not cleared by reads
		for (i = 0; i < 3; i++) begin
			@(posedge sys_clk);
			tx_drop[2] <= 1'b1;
			rx_drop[4] <= (i < 2);
			@(posedge sys_clk);
			tx_drop <= '0;
			rx_drop <= '0;
		end
		run_cmd(9'h102, r);
		check("tx drop", 32'h0000_0003, r);
		run_cmd(9'h109, r);
		check("rx drop", 32'h0000_0002, r);
		run_cmd(9'h102, r);
		check("tx drop reread", 32'h0000_0003, r);
		sw_read(4'hF, r);
		check("unmapped register", 32'h0000_0000, r);
		// Refused port field gives an invalid word; the host rereads once
		run_cmd(9'h0A0, r);
		check("refused address", 32'h0000_0000, r);
		sw_read(HREG_STATUS, r);
		check("retry flag", 32'h0000_0008, r);
		// A near-full lap of one drop counter wraps it and raises its wrap bit
		sw_read(HREG_DROP_WRAP, r);
		check("no wrap yet", 32'h0000_0000, r);
		@(posedge sys_clk);
		tx_drop[2] <= 1'b1;
		repeat (65534) @(posedge sys_clk);
		tx_drop[2] <= 1'b0;
		run_cmd(9'h102, r);
		check("tx drop wrapped", 32'h0000_0001, r);
		sw_read(HREG_DROP_WRAP, r);
		check("wrap flag", 32'h0000_0004, r);
		sw_write(HREG_DROP_WRAP, 32'h0000_0004);
		sw_read(HREG_DROP_WRAP, r);
		check("wrap flag cleared", 32'h0000_0000, r);
		conclude();
	end
endmodule : psc_counter_bank_tb
`default_nettype wire
